// ---- hdl/cspp_pkg.sv ----
// Operation
// RULE1: Gain policy: AGC or fixed per-channel gains.
// RULE2: Gain tune finds channel gains within 3 s.
// RULE3: Gain tune ends in fixed mode, new gains.
// RULE4: AGC reports subtraction off, ignores its changes.
// RULE5: Enabled subtraction removes per-stream offset.
// RULE6: Offsets start at zero.
// RULE7: Offset tune captures each stream, about 2 s.
// RULE8: Offset tune ends with subtraction enabled.
// RULE9: Smoothing filter bypassed or applied, all channels.
// RULE10: Filter: sixth-order Butterworth IIR, cutoff rate/8.
// RULE11: Angular mode computes alpha and beta per channel.
// RULE12: Angles go to analog and serial outputs.
// RULE13: Settings change only at frame boundaries. Gain tune end sets fixed mode and OFF_DIS on its count, not at a boundary.
package cspp_pkg;
	localparam int LEN_W = 16;
	localparam int IDX_W = 4;
	localparam int SLOTS = 16;
	localparam int GAIN_W = 4;
	localparam int CHANS = 4;
	localparam int CORD_W = 20;
	localparam int CORD_ITER = 14;
	localparam int COEF_FRAC = 14;
	localparam logic [1:0] GAIN_AGC = 2'h1;
	localparam logic [1:0] GAIN_FIXED = 2'h2;
	localparam logic [1:0] GAIN_TUNE = 2'h3;
	localparam logic [1:0] OFF_LOCKED = 2'h0;
	localparam logic [1:0] OFF_DIS = 2'h1;
	localparam logic [1:0] OFF_EN = 2'h2;
	localparam logic [1:0] OFF_TUNE = 2'h3;
	localparam logic [1:0] FILT_DIS = 2'h1;
	localparam logic [1:0] FILT_EN = 2'h2;
	localparam logic [1:0] OUT_ANGLE = 2'h1;
	localparam logic [GAIN_W-1:0] GAIN_RESET = 4'h0;
	localparam logic [LEN_W-1:0] OFFSET_RESET = 16'h0;
	localparam logic [15:0] ANG_HALF = 16'h8000;
	localparam int CLK_HZ = 20000000;
	localparam int GAIN_CAL_MS = 3000;
	localparam int OFF_CAL_MS = 2000;
	localparam int GAIN_CAL_CYC = GAIN_CAL_MS * (CLK_HZ / 1000);
	localparam int OFF_CAL_CYC = OFF_CAL_MS * (CLK_HZ / 1000);
	// Magnitude gain of the vectoring loop, Q14
	localparam int CORD_GAIN = 26981;
	// Biquad sections, Q14, bilinear at fs/8
	localparam int BQ0_B0 = 1426;
	localparam int BQ0_A1 = -13767;
	localparam int BQ0_A2 = 3086;
	localparam int BQ1_B0 = 1600;
	localparam int BQ1_A1 = -15447;
	localparam int BQ1_A2 = 5461;
	localparam int BQ2_B0 = 2028;
	localparam int BQ2_A1 = -19586;
	localparam int BQ2_A2 = 11315;

	typedef enum logic [2:0] {CAL_IDLE = 3'b001, CAL_GAIN = 3'b010, CAL_OFF = 3'b100} cspp_cal_t;
	typedef enum logic [3:0] {ANG_IDLE = 4'b0001, ANG_ALPHA = 4'b0010, ANG_BETA = 4'b0100,
		ANG_OUT = 4'b1000} cspp_ang_t;

	function automatic logic signed [LEN_W-1:0] cspp_sat(input logic signed [39:0] v);
		if (v > 40'sh0000007fff)
			return 16'sh7fff;
		else if (v < -40'sh0000008000)
			return -16'sh8000;
		return v[LEN_W-1:0];
	endfunction : cspp_sat

	function automatic logic [15:0] cspp_atan(input logic [3:0] i);
		case (i)
			4'h0: return 16'h2000;
			4'h1: return 16'h12e4;
			4'h2: return 16'h09fb;
			4'h3: return 16'h0511;
			4'h4: return 16'h028b;
			4'h5: return 16'h0146;
			4'h6: return 16'h00a3;
			4'h7: return 16'h0051;
			4'h8: return 16'h0029;
			4'h9: return 16'h0014;
			4'ha: return 16'h000a;
			4'hb: return 16'h0005;
			4'hc: return 16'h0003;
			default: return 16'h0001;
		endcase
	endfunction : cspp_atan
endpackage : cspp_pkg

// ---- hdl/cspp_biquad.sv ----
`timescale 1ns/1ns
module cspp_biquad
	import cspp_pkg::*;
#(
	parameter int B0 = 0,
	parameter int A1 = 0,
	parameter int A2 = 0
)(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Sample in
	input wire logic inValid,
	input wire logic [IDX_W-1:0] inIdx,
	input wire logic inLast,
	input wire logic [1:0] inTag,
	input wire logic signed [LEN_W-1:0] inData,
	// Sample out
	output logic outValid,
	output logic [IDX_W-1:0] outIdx,
	output logic outLast,
	output logic [1:0] outTag,
	output logic signed [LEN_W-1:0] outData
);
	logic signed [39:0] s1Mem [SLOTS];
	logic signed [39:0] s2Mem [SLOTS];
	logic signed [39:0] bx, s1D, s2D;
	logic signed [LEN_W-1:0] yD;

	// ----------------------------------------
	// One transposed section per stream slot
	// ----------------------------------------
	always_comb
	begin
		bx = 40'(B0) * 40'(inData);
		yD = cspp_sat((bx + s1Mem[inIdx]) >>> COEF_FRAC);
		s1D = (bx <<< 1) - 40'(A1) * 40'(yD) + s2Mem[inIdx];
		s2D = bx - 40'(A2) * 40'(yD);
		// Bypass flushes history so re-enabling starts clean
		if (inTag[0])
		begin
			yD = inData; // [RULE9]
			s1D = '0;
			s2D = '0;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			outValid <= 1'b0;
			outIdx <= '0;
			outLast <= 1'b0;
			outTag <= '0;
			outData <= '0;
			for (int i = 0; i < SLOTS; i++)
			begin
				s1Mem[i] <= '0;
				s2Mem[i] <= '0;
			end
		end
		else
		begin
			outValid <= inValid;
			outIdx <= inIdx;
			outLast <= inLast;
			outTag <= inTag;
			outData <= yD;
			if (inValid)
			begin
				s1Mem[inIdx] <= s1D; // [RULE10]
				s2Mem[inIdx] <= s2D;
			end
		end
	end
endmodule : cspp_biquad

// ---- hdl/cspp_postprocess.sv ----
`timescale 1ns/1ns
module cspp_postprocess
	import cspp_pkg::*;
#(
	parameter int GAIN_CAL_CYCLES = GAIN_CAL_CYC,
	parameter int OFF_CAL_CYCLES = OFF_CAL_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Setting requests
	input wire logic [1:0] gainModeReq,
	input wire logic [1:0] offCorrReq,
	input wire logic [1:0] filterReq,
	input wire logic [1:0] outModeReq,
	// Remote adjustment
	input wire logic gainWrEn,
	input wire logic [1:0] gainWrChan,
	input wire logic [GAIN_W-1:0] gainWrData,
	input wire logic offWrEn,
	input wire logic [IDX_W-1:0] offWrIdx,
	input wire logic signed [LEN_W-1:0] offWrData,
	// Vector lengths in
	input wire logic sampleValid,
	input wire logic [1:0] sampleChan,
	input wire logic [1:0] sampleFreq,
	input wire logic sampleLast,
	input wire logic signed [LEN_W-1:0] sampleLen,
	// Status
	output logic gainIsFixed,
	output logic [CHANS*GAIN_W-1:0] fixedGains,
	output logic [1:0] offCorrState,
	output logic filterOn,
	output logic [1:0] outModeState,
	output logic gainCalBusy,
	output logic offCalBusy,
	// Processed stream
	output logic procValid,
	output logic [IDX_W-1:0] procIdx,
	output logic signed [LEN_W-1:0] procLen,
	// Angle results
	output logic angValid,
	output logic [1:0] angChan,
	output logic [15:0] angAlpha,
	output logic [15:0] angBeta,
	output logic [15:0] dacAlpha,
	output logic [15:0] dacBeta
);
	logic [1:0] gainMode_q, gainMode_d, offCorr_q, offCorr_d, filt_q, filt_d, outMode_q, outMode_d;
	logic [1:0] gainPrev_q, offPrev_q;
	cspp_cal_t cal_q, cal_d;
	logic [31:0] calCnt_q, calCnt_d;
	logic [CHANS*GAIN_W-1:0] gains_q, gains_d;
	logic [LEN_W-1:0] peak_q [CHANS];
	logic [LEN_W-1:0] peak_d [CHANS];
	logic signed [LEN_W-1:0] offMem [SLOTS];
	logic inFire, boundary, subOn;
	logic [IDX_W-1:0] inIdx;
	logic [LEN_W-1:0] mag;
	logic s0Valid, s0Last;
	logic [IDX_W-1:0] s0Idx;
	logic [1:0] s0Tag;
	logic signed [LEN_W-1:0] s0Data;
	logic cValid [4];
	logic cLast [4];
	logic [IDX_W-1:0] cIdx [4];
	logic [1:0] cTag [4];
	logic signed [LEN_W-1:0] cData [4];

	assign inFire = sampleValid;
	assign boundary = inFire && sampleLast;
	assign inIdx = 4'({2'h0, sampleChan} * 4'h3 + {2'h0, sampleFreq});
	assign mag = sampleLen[LEN_W-1] ? 16'(-sampleLen) : sampleLen;
	assign subOn = gainMode_q == GAIN_FIXED && offCorr_q == OFF_EN && cal_q != CAL_OFF;

	function automatic logic [GAIN_W-1:0] gainCode(input logic [LEN_W-1:0] p);
		logic [GAIN_W-1:0] code;
		code = 4'hf;
		// Headroom of one bit below full scale
		for (int b = 0; b < LEN_W - 1; b++)
			if (p[b])
				code = 4'(LEN_W - 2 - b);
		return code;
	endfunction : gainCode

	// ----------------------------------------
	// Settings and calibration
	// ----------------------------------------
	always_comb
	begin
		gainMode_d = gainMode_q;
		offCorr_d = offCorr_q;
		filt_d = filt_q;
		outMode_d = outMode_q;
		cal_d = cal_q;
		calCnt_d = calCnt_q;
		gains_d = gains_q;
		peak_d = peak_q;
		if (gainWrEn)
			gains_d[gainWrChan*GAIN_W +: GAIN_W] = gainWrData;
		case (cal_q)
			CAL_IDLE:
			begin
				if (gainModeReq == GAIN_TUNE && gainPrev_q != GAIN_TUNE)
				begin
					cal_d = CAL_GAIN;
					calCnt_d = '0;
					for (int c = 0; c < CHANS; c++)
						peak_d[c] = '0;
				end
				else if (offCorrReq == OFF_TUNE && offPrev_q != OFF_TUNE && gainMode_q == GAIN_FIXED)
				begin
					cal_d = CAL_OFF; // [RULE7]
					calCnt_d = '0;
				end
				else if (boundary) // [RULE13]
				begin
					if (gainModeReq == GAIN_AGC || gainModeReq == GAIN_FIXED)
						gainMode_d = gainModeReq; // [RULE1]
					// Locked while the gain follows the AGC
					if (gainMode_q == GAIN_FIXED && (offCorrReq == OFF_DIS || offCorrReq == OFF_EN))
						offCorr_d = offCorrReq; // [RULE4]
					if (filterReq == FILT_DIS || filterReq == FILT_EN)
						filt_d = filterReq;
					if (outModeReq != 2'h0)
						outMode_d = outModeReq;
				end
			end
			CAL_GAIN:
			begin
				calCnt_d = calCnt_q + 32'h1;
				if (inFire && mag > peak_q[sampleChan])
					peak_d[sampleChan] = mag; // [RULE2]
				// Ends on the count, never past the limit
				if (calCnt_q >= 32'(GAIN_CAL_CYCLES - 1))
				begin
					for (int c = 0; c < CHANS; c++)
						gains_d[c*GAIN_W +: GAIN_W] = gainCode(peak_q[c]); // [RULE2]
					gainMode_d = GAIN_FIXED; // [RULE3]
					offCorr_d = OFF_DIS;
					cal_d = CAL_IDLE;
				end
			end
			CAL_OFF:
			begin
				if (calCnt_q < 32'(OFF_CAL_CYCLES))
					calCnt_d = calCnt_q + 32'h1;
				else if (boundary)
				begin
					offCorr_d = OFF_EN; // [RULE8]
					cal_d = CAL_IDLE;
				end
			end
			default: cal_d = CAL_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gainMode_q <= GAIN_AGC;
			offCorr_q <= OFF_DIS;
			filt_q <= FILT_DIS;
			outMode_q <= OUT_ANGLE;
			gainPrev_q <= '0;
			offPrev_q <= '0;
			cal_q <= CAL_IDLE;
			calCnt_q <= '0;
			gains_q <= {CHANS{GAIN_RESET}};
			for (int c = 0; c < CHANS; c++)
				peak_q[c] <= '0;
		end
		else
		begin
			gainMode_q <= gainMode_d;
			offCorr_q <= offCorr_d;
			filt_q <= filt_d;
			outMode_q <= outMode_d;
			gainPrev_q <= gainModeReq;
			offPrev_q <= offCorrReq;
			cal_q <= cal_d;
			calCnt_q <= calCnt_d;
			gains_q <= gains_d;
			peak_q <= peak_d;
		end
	end

	assign gainIsFixed = gainMode_q == GAIN_FIXED;
	assign fixedGains = gains_q;
	assign offCorrState = gainIsFixed ? offCorr_q : OFF_LOCKED; // [RULE4]
	assign filterOn = filt_q == FILT_EN;
	assign outModeState = outMode_q;
	assign gainCalBusy = cal_q == CAL_GAIN;
	assign offCalBusy = cal_q == CAL_OFF;

	// ----------------------------------------
	// Offset store and subtraction
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < SLOTS; i++)
				offMem[i] <= OFFSET_RESET; // [RULE6]
			s0Valid <= 1'b0;
			s0Last <= 1'b0;
			s0Idx <= '0;
			s0Tag <= '0;
			s0Data <= '0;
		end
		else
		begin
			if (cal_q == CAL_OFF && inFire)
				offMem[inIdx] <= sampleLen; // [RULE7]
			else if (offWrEn)
				offMem[offWrIdx] <= offWrData;
			s0Valid <= inFire;
			s0Last <= sampleLast;
			s0Idx <= inIdx;
			// Settings travel with the sample through the pipe
			s0Tag <= {outMode_q == OUT_ANGLE, filt_q != FILT_EN}; // [RULE13]
			s0Data <= subOn ? cspp_sat(40'(sampleLen) - 40'(offMem[inIdx])) : sampleLen; // [RULE5]
		end
	end

	// ----------------------------------------
	// Smoothing filter, three cascaded sections
	// ----------------------------------------
	assign cValid[0] = s0Valid;
	assign cLast[0] = s0Last;
	assign cIdx[0] = s0Idx;
	assign cTag[0] = s0Tag;
	assign cData[0] = s0Data;

	generate
		for (genvar k = 0; k < 3; k++)
		begin : gSec
			localparam int SB0 = k == 0 ? BQ0_B0 : k == 1 ? BQ1_B0 : BQ2_B0;
			localparam int SA1 = k == 0 ? BQ0_A1 : k == 1 ? BQ1_A1 : BQ2_A1;
			localparam int SA2 = k == 0 ? BQ0_A2 : k == 1 ? BQ1_A2 : BQ2_A2;
			cspp_biquad #(.B0(SB0), .A1(SA1), .A2(SA2)) uSec ( // [RULE10]
				.clk(clk),
				.arst_n(arst_n),
				.inValid(cValid[k]),
				.inIdx(cIdx[k]),
				.inLast(cLast[k]),
				.inTag(cTag[k]),
				.inData(cData[k]),
				.outValid(cValid[k+1]),
				.outIdx(cIdx[k+1]),
				.outLast(cLast[k+1]),
				.outTag(cTag[k+1]),
				.outData(cData[k+1])
			);
		end
	endgenerate

	assign procValid = cValid[3];
	assign procIdx = cIdx[3];
	assign procLen = cData[3];

	// ----------------------------------------
	// Angle computation
	// ----------------------------------------
	cspp_ang_t ang_q, ang_d;
	logic signed [LEN_W-1:0] vec_q [SLOTS];
	logic [1:0] ch_q, ch_d;
	logic [3:0] it_q, it_d;
	logic signed [CORD_W-1:0] x_q, x_d, y_q, y_d;
	logic [15:0] z_q, z_d, alpha_q, alpha_d;
	logic [IDX_W-1:0] base;
	logic signed [LEN_W-1:0] fx, fy;

	// A frame that ends while the engine is busy is not turned into angles
	always_comb
	begin
		ang_d = ang_q;
		ch_d = ch_q;
		it_d = it_q;
		x_d = x_q;
		y_d = y_q;
		z_d = z_q;
		alpha_d = alpha_q;
		base = 4'({2'h0, ch_q} * 4'h3);
		fx = vec_q[base];
		fy = vec_q[base + 4'h1];
		case (ang_q)
			ANG_IDLE:
				if (cValid[3] && cLast[3] && cTag[3][1])
				begin
					ch_d = '0;
					ang_d = ANG_OUT;
					it_d = 4'hf;
				end
			ANG_ALPHA, ANG_BETA:
			begin
				if (!y_q[CORD_W-1])
				begin
					x_d = x_q + (y_q >>> it_q);
					y_d = y_q - (x_q >>> it_q);
					z_d = z_q + cspp_atan(it_q);
				end
				else
				begin
					x_d = x_q - (y_q >>> it_q);
					y_d = y_q + (x_q >>> it_q);
					z_d = z_q - cspp_atan(it_q);
				end
				it_d = it_q + 4'h1;
				if (it_q == 4'(CORD_ITER - 1))
				begin
					it_d = '0;
					if (ang_q == ANG_ALPHA)
					begin
						alpha_d = z_d; // [RULE11]
						// Scale the third length by the loop gain to match the hypotenuse in X
						y_d = CORD_W'((36'(vec_q[base + 4'h2]) * 36'(CORD_GAIN)) >>> COEF_FRAC);
						z_d = '0;
						ang_d = ANG_BETA;
					end
					else
						ang_d = ANG_OUT; // [RULE11]
				end
			end
			ANG_OUT:
			begin
				if (it_q != 4'hf)
					ch_d = ch_q + 2'h1;
				if (it_q != 4'hf && ch_q == 2'h3)
					ang_d = ANG_IDLE;
				else
				begin
					if (it_q != 4'hf)
						base = 4'({2'h0, ch_d} * 4'h3);
					fx = vec_q[base];
					fy = vec_q[base + 4'h1];
					// Left half plane folds over by half a turn
					x_d = fx[LEN_W-1] ? -CORD_W'(fx) : CORD_W'(fx);
					y_d = fx[LEN_W-1] ? -CORD_W'(fy) : CORD_W'(fy);
					z_d = fx[LEN_W-1] ? ANG_HALF : 16'h0;
					it_d = '0;
					ang_d = ANG_ALPHA;
				end
			end
			default: ang_d = ANG_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ang_q <= ANG_IDLE;
			ch_q <= '0;
			it_q <= '0;
			x_q <= '0;
			y_q <= '0;
			z_q <= '0;
			alpha_q <= '0;
			angValid <= 1'b0;
			angChan <= '0;
			angAlpha <= '0;
			angBeta <= '0;
			dacAlpha <= ANG_HALF;
			dacBeta <= ANG_HALF;
			for (int i = 0; i < SLOTS; i++)
				vec_q[i] <= '0;
		end
		else
		begin
			ang_q <= ang_d;
			ch_q <= ch_d;
			it_q <= it_d;
			x_q <= x_d;
			y_q <= y_d;
			z_q <= z_d;
			alpha_q <= alpha_d;
			if (cValid[3] && ang_q == ANG_IDLE)
				vec_q[cIdx[3]] <= cData[3];
			angValid <= ang_q == ANG_OUT && it_q != 4'hf;
			if (ang_q == ANG_OUT && it_q != 4'hf)
			begin
				angChan <= ch_q; // [RULE12]
				angAlpha <= alpha_q;
				angBeta <= z_q;
				dacAlpha <= alpha_q ^ ANG_HALF; // [RULE12]
				dacBeta <= z_q ^ ANG_HALF;
			end
		end
	end
endmodule : cspp_postprocess

// ---- dv/cspp_postprocess_assertions.sv ----
`timescale 1ns/1ns
module cspp_postprocess_assertions
	import cspp_pkg::*;
#(
	parameter int GAIN_CAL_CYCLES = 200,
	parameter int OFF_CAL_CYCLES = 100
)(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Requests and stream
	input wire logic [1:0] gainModeReq,
	input wire logic [1:0] offCorrReq,
	input wire logic sampleValid,
	input wire logic sampleLast,
	// Status
	input wire logic gainIsFixed,
	input wire logic [1:0] offCorrState,
	input wire logic filterOn,
	input wire logic [1:0] outModeState,
	input wire logic gainCalBusy,
	input wire logic offCalBusy,
	// Results
	input wire logic procValid,
	input wire logic angValid,
	input wire logic [15:0] angAlpha,
	input wire logic [15:0] dacAlpha
);
	// ----
	// Busy length counters
	// ----
	logic [31:0] gCnt_q, gCnt_d, oCnt_q, oCnt_d;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	always_comb
	begin
		gCnt_d = gainCalBusy ? gCnt_q + 32'h1 : 32'h0;
		oCnt_d = offCalBusy ? oCnt_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gCnt_q <= 32'h0;
			oCnt_q <= 32'h0;
		end
		else
		begin
			gCnt_q <= gCnt_d;
			oCnt_q <= oCnt_d;
		end
	end
	property p_procLat;
		sampleValid |-> ##4 procValid;
	endproperty
	a_procLat: assert property (p_procLat) else $error("proc latency");
	property p_agcOff;
		!gainIsFixed |-> offCorrState == OFF_LOCKED;
	endproperty
	a_agcOff: assert property (p_agcOff) else $error("agc offset state");
	property p_gainGo;
		!gainCalBusy && !offCalBusy && gainModeReq == GAIN_TUNE && $past(gainModeReq) != GAIN_TUNE |=> gainCalBusy;
	endproperty
	a_gainGo: assert property (p_gainGo) else $error("gain tune start");
	property p_gainLen;
		$fell(gainCalBusy) |-> gCnt_q == GAIN_CAL_CYCLES;
	endproperty
	a_gainLen: assert property (p_gainLen) else $error("gain tune length");
	property p_gainEnd;
		$fell(gainCalBusy) |-> gainIsFixed && offCorrState == OFF_DIS;
	endproperty
	a_gainEnd: assert property (p_gainEnd) else $error("gain tune end");
	property p_offGo;
		gainIsFixed && !gainCalBusy && !offCalBusy && offCorrReq == OFF_TUNE && $past(offCorrReq) != OFF_TUNE
			|=> offCalBusy;
	endproperty
	a_offGo: assert property (p_offGo) else $error("offset tune start");
	property p_offEnd;
		$fell(offCalBusy) |-> offCorrState == OFF_EN && oCnt_q > OFF_CAL_CYCLES;
	endproperty
	a_offEnd: assert property (p_offEnd) else $error("offset tune end");
	property p_frameSet;
		$changed(filterOn) || $changed(outModeState) |-> $past(sampleValid) && $past(sampleLast);
	endproperty
	a_frameSet: assert property (p_frameSet) else $error("setting off boundary");
	property p_angDac;
		angValid |-> dacAlpha == (angAlpha ^ ANG_HALF);
	endproperty
	a_angDac: assert property (p_angDac) else $error("dac copy");
	property p_angPulse;
		angValid |=> !angValid;
	endproperty
	a_angPulse: assert property (p_angPulse) else $error("angle pulse");
	c_gain: cover property ($fell(gainCalBusy));
	c_off: cover property ($fell(offCalBusy));
	c_ang: cover property (angValid);
endmodule : cspp_postprocess_assertions
bind cspp_postprocess cspp_postprocess_assertions #(
	.GAIN_CAL_CYCLES(GAIN_CAL_CYCLES),
	.OFF_CAL_CYCLES(OFF_CAL_CYCLES)
) i_chk (.clk, .arst_n, .gainModeReq, .offCorrReq, .sampleValid, .sampleLast, .gainIsFixed, .offCorrState,
	.filterOn, .outModeState, .gainCalBusy, .offCalBusy, .procValid, .angValid, .angAlpha, .dacAlpha);

// ---- dv/cspp_frame_source.sv ----
`timescale 1ns/1ns
module cspp_frame_source
	import cspp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic go,
	input wire logic slow,
	input wire logic signed [LEN_W-1:0] words [12],
	output logic busy,
	// Sample stream
	output logic sampleValid,
	output logic [1:0] sampleChan,
	output logic [1:0] sampleFreq,
	output logic sampleLast,
	output logic signed [LEN_W-1:0] sampleLen
);
	int n;
	logic gap;
	assign busy = n < 12;
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			n <= 12;
			gap <= 1'b0;
			sampleValid <= 1'b0;
			sampleLast <= 1'b0;
			sampleChan <= 2'h0;
			sampleFreq <= 2'h0;
			sampleLen <= 16'sh0;
		end
		else if (n < 12 && !gap)
		begin
			sampleValid <= 1'b1;
			sampleChan <= 2'(n / 3);
			sampleFreq <= 2'(n % 3);
			sampleLast <= n == 11;
			sampleLen <= words[n];
			n <= n + 1;
			gap <= slow;
		end
		else
		begin
			// Idle word flips so a stale value never looks valid
			sampleValid <= 1'b0;
			sampleLast <= 1'b0;
			sampleLen <= ~sampleLen;
			gap <= 1'b0;
			if (go)
				n <= 0;
		end
	end
endmodule : cspp_frame_source

// ---- dv/cspp_postprocess_bench.sv ----
`timescale 1ns/1ns
module cspp_postprocess_bench;
	import cspp_pkg::*;
	logic clk, arst_n, gainWrEn, offWrEn, go, slow, busy, angChk;
	logic sampleValid, sampleLast, gainIsFixed, filterOn, gainCalBusy, offCalBusy, procValid, angValid;
	logic [1:0] gainModeReq, offCorrReq, filterReq, outModeReq, gainWrChan;
	logic [1:0] sampleChan, sampleFreq, offCorrState, outModeState, angChan;
	logic [GAIN_W-1:0] gainWrData;
	logic [IDX_W-1:0] offWrIdx, procIdx;
	logic signed [LEN_W-1:0] offWrData, sampleLen, procLen;
	logic signed [LEN_W-1:0] words [12];
	logic signed [LEN_W-1:0] offs [12];
	logic [15:0] fixedGains, angAlpha, angBeta, g, dacAlpha, dacBeta;
	logic [20:0] expQ [$];
	int bad_count, num_checks, nAng, k;
	cspp_postprocess #(.GAIN_CAL_CYCLES(200), .OFF_CAL_CYCLES(100)) i_dut (.clk, .arst_n, .gainModeReq,
		.offCorrReq, .filterReq, .outModeReq, .gainWrEn, .gainWrChan, .gainWrData, .offWrEn, .offWrIdx,
		.offWrData, .sampleValid, .sampleChan, .sampleFreq, .sampleLast, .sampleLen, .gainIsFixed, .fixedGains,
		.offCorrState, .filterOn, .outModeState, .gainCalBusy, .offCalBusy, .procValid, .procIdx, .procLen,
		.angValid, .angChan, .angAlpha, .angBeta, .dacAlpha, .dacBeta);
	cspp_frame_source i_src (.clk, .arst_n, .go, .slow, .words, .busy, .sampleValid, .sampleChan,
		.sampleFreq, .sampleLast, .sampleLen);
	// ----
	// Checking helpers
	// ----
	task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmpVal
	task automatic cmpNear(input logic [15:0] got, input logic [15:0] exp);
		logic [15:0] d;
		num_checks++;
		d = got - exp;
		if ($isunknown(got) || (d > 16'h0010 && d < 16'hfff0))
		begin
			bad_count++;
			$display("wrong value at %0t: angle %h near %h", $time, got, exp);
		end
	endtask : cmpNear
	function automatic logic [15:0] subSat(input logic signed [15:0] a, input logic signed [15:0] b);
		int r;
		r = int'(a) - int'(b);
		r = r > 32767 ? 32767 : (r < -32768 ? -32768 : r);
		return 16'(r);
	endfunction : subSat
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	task automatic sendFrame(input logic chk, input logic sub);
		for (int i = 0; i < 12; i++)
			expQ.push_back({chk, 4'(i), sub ? subSat(words[i], offs[i]) : words[i]});
		@(posedge clk);
		slow <= 1'($urandom);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do @(negedge clk); while (busy);
		repeat (6) @(negedge clk);
	endtask : sendFrame
	task automatic wrOff(input int i, input logic [15:0] v);
		@(posedge clk);
		offWrEn <= 1'b1;
		offWrIdx <= 4'(i);
		offWrData <= v;
		@(posedge clk);
		offWrEn <= 1'b0;
	endtask : wrOff
	always @(posedge clk)
		if (procValid === 1'b1 && expQ.size() > 0)
		begin
			if (expQ[0][20])
				cmpVal({procIdx, procLen[11:0]}, {expQ[0][19:16], 12'h0} | 16'(expQ[0][11:0]));
			if (expQ[0][20])
				cmpVal(procLen, expQ[0][15:0]);
			void'(expQ.pop_front());
		end
	always @(posedge clk)
		if (angValid === 1'b1 && angChk)
		begin
			nAng++;
			cmpNear(angAlpha, 16'h2000);
			cmpNear(angBeta, 16'h0000);
			cmpVal(16'(angChan), 16'(nAng - 1));
			cmpNear(dacBeta, 16'h8000);
			cmpNear(dacAlpha, 16'ha000);
		end
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		#(20000 * 50);
		bad_count++;
		final_report();
	end
	initial
	begin
		{arst_n, gainWrEn, offWrEn, go, slow, angChk, gainWrChan, gainWrData, offWrIdx, offWrData} = '0;
		{gainModeReq, offCorrReq, filterReq, outModeReq} = {GAIN_AGC, OFF_DIS, FILT_DIS, OUT_ANGLE};
		for (int i = 0; i < 12; i++)
			offs[i] = 16'sh0;
		void'($urandom(75690));
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		cmpVal({gainIsFixed, filterOn, offCorrState, fixedGains[11:0]}, 16'h0);
		cmpVal({14'h0, outModeState}, {14'h0, OUT_ANGLE});
		cmpVal(dacBeta, 16'h8000);
		$display("test reset done");
		@(posedge clk);
		offCorrReq <= OFF_EN;
		angChk = 1'b1;
		for (int i = 0; i < 12; i++)
			words[i] = (i % 3 == 2) ? 16'sh0 : 16'sh03e8;
		sendFrame(1'b1, 1'b0);
		repeat (130) @(negedge clk);
		angChk = 1'b0;
		cmpVal(16'(nAng), 16'h4);
		cmpVal(16'(offCorrState), 16'h0);
		$display("test agc and angles done");
		gainModeReq <= GAIN_FIXED;
		offCorrReq <= OFF_DIS;
		sendFrame(1'b1, 1'b0);
		cmpVal({15'h0, gainIsFixed}, 16'h1);
		offCorrReq <= OFF_EN;
		sendFrame(1'b1, 1'b0);
		cmpVal(16'(offCorrState), 16'(OFF_EN));
		for (int i = 0; i < 12; i++)
			words[i] = 16'($urandom);
		sendFrame(1'b1, 1'b1);
		$display("test fixed mode done");
		for (int i = 0; i < 12; i++)
			offs[i] = 16'($urandom);
		{words[0], offs[0], words[1], offs[1]} = {16'sh8000, 16'sh7fff, 16'sh7fff, 16'sh8000};
		for (int i = 0; i < 12; i++)
			wrOff(i, offs[i]);
		offCorrReq <= OFF_DIS;
		sendFrame(1'b1, 1'b1);
		sendFrame(1'b1, 1'b0);
		@(posedge clk);
		gainWrEn <= 1'b1;
		gainWrChan <= 2'h2;
		gainWrData <= 4'h5;
		@(posedge clk);
		gainWrEn <= 1'b0;
		@(negedge clk);
		cmpVal(16'(fixedGains[11:8]), 16'h5);
		$display("test remote offsets done");
		offCorrReq <= OFF_TUNE;
		for (int i = 0; i < 12; i++)
			words[i] = 16'($urandom_range(0, 4000)) - 16'sd2000;
		k = 0;
		do
		begin
			sendFrame(1'b0, 1'b0);
			k++;
		end
		while (offCalBusy === 1'b1 && k < 30);
		offCorrReq <= OFF_EN;
		cmpVal(16'(offCorrState), 16'(OFF_EN));
		offs = words;
		sendFrame(1'b1, 1'b1);
		$display("test offset tune done");
		gainModeReq <= GAIN_TUNE;
		g = 16'h0;
		for (int i = 0; i < 12; i++)
			words[i] = (i % 3 == 1) ? -(16'sh0010 << (i / 3)) : 16'sh0004;
		for (int c = 0; c < 4; c++)
			g[4 * c +: 4] = 4'(10 - c);
		sendFrame(1'b0, 1'b0);
		k = 0;
		while (gainCalBusy === 1'b1 && k < 400)
		begin
			@(negedge clk);
			k++;
		end
		cmpVal(fixedGains, g);
		cmpVal({gainIsFixed, 13'h0, offCorrState}, {1'b1, 13'h0, OFF_DIS});
		gainModeReq <= GAIN_FIXED;
		$display("test gain tune done");
		repeat (4)
		begin
			filterReq <= 2'($urandom_range(1, 2));
			sendFrame(1'b0, 1'b0);
		end
		filterReq <= FILT_EN;
		sendFrame(1'b0, 1'b0);
		cmpVal({15'h0, filterOn}, 16'h1);
		gainModeReq <= GAIN_AGC;
		sendFrame(1'b0, 1'b0);
		cmpVal(16'(offCorrState), 16'h0);
		$display("test filter and agc done");
		final_report();
	end
endmodule : cspp_postprocess_bench
